/* File: verilog/sfp_frame_pop.sv */
// Execution logic for the save-index decrement leaf
`timescale 1ns/1ps
`include "sfp_defs.svh"
module sfp_frame_pop #(
   parameter int MAX_PAGES = 16
) (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic op_valid_in,
   input wire logic [7:0] leaf_sel_in,
   input wire logic in_enclave_in,
   input wire logic thread_busy_in,
   input wire logic mode64_in,
   input wire logic flow_cap_in,
   input wire logic shadow_stack_enable_in,
   input wire logic branch_tracking_enable_in,
   input wire logic [`SFP_IDX_W-1:0] current_save_index_in,
   input wire logic [63:0] save_area_offset_in,
   input wire logic [63:0] flow_save_offset_in,
   input wire logic [63:0] enclave_base_in,
   input wire logic [`SFP_PG_CNT_W-1:0] save_frame_pages_in,
   input wire logic [`SFP_PG_CNT_W-1:0] xsave_pages_in,
   input wire logic [63:0] reg_area_bytes_in,
   input wire logic [63:0] ds_limit_in,
   input wire logic pg_in_cache_in,
   input wire logic pg_valid_in,
   input wire logic pg_blocked_in,
   input wire logic pg_pending_in,
   input wire logic pg_modified_in,
   input wire logic pg_rd_in,
   input wire logic pg_wr_in,
   input wire logic [63:0] pg_enclave_addr_in,
   input wire logic pg_owner_match_in,
   input wire sfp_pkg::sfp_ptype_t pg_type_in,
   input wire logic [63:0] pg_phys_in,
   output logic [63:0] probe_addr_out,
   output logic thread_lock_out,
   output logic done_out,
   output sfp_pkg::sfp_fault_t fault_out,
   output logic [63:0] fault_addr_out,
   output logic index_wr_out,
   output logic [`SFP_IDX_W-1:0] index_wdata_out,
   output logic [63:0] reg_area_pa_out,
   output logic [MAX_PAGES*64-1:0] xsave_pa_out
);
   import sfp_pkg::*;

   typedef enum logic [2:0] {
      SFP_IDLE, SFP_XPAGE, SFP_GPR, SFP_FLOW, SFP_COMMIT, SFP_END
   } sfp_state_t;

   typedef struct packed {
      sfp_state_t st;
      logic [63:0] frame;
      logic [63:0] gpr;
      logic [63:0] flow;
      logic [63:0] probe;
      logic [`SFP_PG_CNT_W-1:0] pg;
      logic [`SFP_PG_CNT_W-1:0] pg_last;
      logic [`SFP_IDX_W-1:0] idx;
      logic flow_on;
      logic lock;
      logic done;
      sfp_fault_t fault;
      logic [63:0] faddr;
      logic iwr;
      logic [63:0] gpa;
      logic [63:0] tgpa;
      logic [MAX_PAGES*64-1:0] xpa;
      logic [MAX_PAGES*64-1:0] tpa;
   } sfp_regs_t;

   sfp_regs_t q;
   sfp_regs_t d;
   logic pg_ok;
   logic type_ok;
   logic [63:0] idx_m1;
   logic [63:0] frame_bytes;

   assign type_ok = (q.st == SFP_FLOW) ? (pg_type_in == SFP_SHADOW_RESTORE_PAGE_TYPE)
                                       : (pg_type_in == SFP_REGULAR_PAGE_TYPE);
   assign idx_m1 = 64'(current_save_index_in) - 64'h1;
   assign frame_bytes = 64'(save_frame_pages_in) << `SFP_PAGE_SHIFT;

   sfp_page_check u_chk (
      .in_cache_in(pg_in_cache_in),
      .valid_in(pg_valid_in),
      .blocked_in(pg_blocked_in),
      .pending_in(pg_pending_in),
      .modified_in(pg_modified_in),
      .rd_in(pg_rd_in),
      .wr_in(pg_wr_in),
      .addr_match_in(pg_enclave_addr_in == (q.probe & `SFP_PAGE_MASK)),
      .owner_match_in(pg_owner_match_in),
      .type_match_in(type_ok),
      .ok_out(pg_ok)
   );

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.iwr = 1'b0;
      unique case (q.st)
         SFP_IDLE: begin
            if (op_valid_in && leaf_sel_in == `SFP_LEAF_SEL) begin
               d.done = 1'b1;
               d.fault = SFP_FAULT_GP;
               d.faddr = 64'h0;
               // First failing check wins
               if (!in_enclave_in) begin
                  d.st = SFP_IDLE;
               end else if (thread_busy_in) begin
                  d.st = SFP_IDLE;
               end else if (current_save_index_in == '0) begin
                  d.st = SFP_IDLE;
               end else begin
                  d.done = 1'b0;
                  d.fault = SFP_FAULT_NONE;
                  d.lock = 1'b1;
                  d.idx = current_save_index_in;
                  d.frame = save_area_offset_in + enclave_base_in
                     + 64'(frame_bytes * idx_m1);
                  d.gpr = save_area_offset_in + enclave_base_in
                     + 64'(frame_bytes * idx_m1) + frame_bytes - reg_area_bytes_in;
                  d.flow = (flow_save_offset_in + enclave_base_in
                     + 64'(idx_m1 * `SFP_FLOW_STRIDE)) & `SFP_PAGE_MASK;
                  d.flow_on = flow_cap_in
                     & (shadow_stack_enable_in | branch_tracking_enable_in);
                  d.pg = '0;
                  d.pg_last = xsave_pages_in;
                  d.probe = save_area_offset_in + enclave_base_in
                     + 64'(frame_bytes * idx_m1);
                  d.st = SFP_XPAGE;
               end
            end
         end
         SFP_XPAGE: begin
            if (!pg_ok) begin
               d.fault = SFP_FAULT_PF;
               d.faddr = q.probe;
               d.st = SFP_END;
            end else begin
               d.tpa[64*int'(q.pg) +: 64] = pg_phys_in;
               if (q.pg == q.pg_last || int'(q.pg) == MAX_PAGES - 1) begin
                  d.probe = q.gpr;
                  d.st = SFP_GPR;
               end else begin
                  d.pg = q.pg + 1'b1;
                  d.probe = q.probe + `SFP_PAGE_BYTES;
               end
            end
         end
         SFP_GPR: begin
            if (!pg_ok) begin
               d.fault = SFP_FAULT_PF;
               d.faddr = q.probe;
               d.st = SFP_END;
            end else if (!mode64_in && (q.gpr + reg_area_bytes_in - 64'h1) > ds_limit_in) begin
               d.fault = SFP_FAULT_GP;
               d.faddr = 64'h0;
               d.st = SFP_END;
            end else begin
               // Held back: a later flow-page fault must not expose it
               d.tgpa = pg_phys_in;
               d.probe = q.flow;
               d.st = q.flow_on ? SFP_FLOW : SFP_COMMIT;
            end
         end
         SFP_FLOW: begin
            if (!pg_ok) begin
               d.fault = SFP_FAULT_PF;
               d.faddr = q.probe;
               d.st = SFP_END;
            end else begin
               d.st = SFP_COMMIT;
            end
         end
         SFP_COMMIT: begin
            d.iwr = 1'b1;
            d.idx = q.idx - 1'b1;
            d.st = SFP_END;
         end
         SFP_END: begin
            // Physical addresses published only on success
            if (q.fault == SFP_FAULT_NONE) begin
               d.xpa = q.tpa;
               d.gpa = q.tgpa;
            end
            d.lock = 1'b0;
            d.done = 1'b1;
            d.st = SFP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
         q.st <= SFP_IDLE;
      end else begin
         q <= d;
      end
   end

   assign probe_addr_out = q.probe;
   assign thread_lock_out = q.lock;
   assign done_out = q.done;
   assign fault_out = q.fault;
   assign fault_addr_out = q.faddr;
   assign index_wr_out = q.iwr;
   assign index_wdata_out = q.idx;
   assign reg_area_pa_out = q.gpa;
   assign xsave_pa_out = q.xpa;

   property p_zero_gp;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         (q.st == SFP_IDLE && op_valid_in && leaf_sel_in == `SFP_LEAF_SEL && in_enclave_in
          && !thread_busy_in && current_save_index_in == '0)
         |=> (done_out && fault_out == SFP_FAULT_GP && !index_wr_out);
   endproperty
   a_zero_gp: assert property (p_zero_gp) else $error("zero index not refused");
   property p_out_gp;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         (q.st == SFP_IDLE && op_valid_in && leaf_sel_in == `SFP_LEAF_SEL && !in_enclave_in)
         |=> (fault_out == SFP_FAULT_GP && !thread_lock_out);
   endproperty
   a_out_gp: assert property (p_out_gp) else $error("outside enclave not refused");
   property p_busy_gp;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         (q.st == SFP_IDLE && op_valid_in && leaf_sel_in == `SFP_LEAF_SEL && in_enclave_in
          && thread_busy_in) |=> (fault_out == SFP_FAULT_GP);
   endproperty
   a_busy_gp: assert property (p_busy_gp) else $error("busy thread not refused");
   sequence s_pf_flag;
      fault_out == SFP_FAULT_PF;
   endsequence
   sequence s_released;
      !index_wr_out && !thread_lock_out && done_out;
   endsequence
   property p_pf_nowr;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         (q.st != SFP_IDLE && q.st != SFP_COMMIT && q.st != SFP_END && !pg_ok)
         |=> s_pf_flag ##1 s_released;
   endproperty
   a_pf_nowr: assert property (p_pf_nowr) else $error("page fault did not abort");
   property p_wr_dec;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         index_wr_out |-> (index_wdata_out == $past(q.idx) - 1'b1 && fault_out == SFP_FAULT_NONE);
   endproperty
   a_wr_dec: assert property (p_wr_dec) else $error("decrement wrong");
   property p_flow_addr;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         (q.st == SFP_FLOW) |-> (probe_addr_out[11:0] == 12'h000);
   endproperty
   a_flow_addr: assert property (p_flow_addr) else $error("flow page not aligned");
   property p_ok_end;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         (q.st == SFP_END) |=> (done_out && !thread_lock_out && q.st == SFP_IDLE);
   endproperty
   a_ok_end: assert property (p_ok_end) else $error("end not released");
   property p_lock_held;
      @(posedge clk_sys_in) disable iff (!rstn_in)
         (q.st == SFP_XPAGE || q.st == SFP_GPR || q.st == SFP_FLOW) |-> thread_lock_out;
   endproperty
   a_lock_held: assert property (p_lock_held) else $error("lock dropped mid walk");
endmodule : sfp_frame_pop

/* File: include/sfp_defs.svh */
// Constants for the state-save-area frame pop leaf
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
`define SFP_LEAF_SEL 8'h09
`define SFP_PAGE_BYTES 64'h1000
`define SFP_PAGE_SHIFT 12
`define SFP_FLOW_STRIDE 64'h10
`define SFP_PAGE_MASK 64'hffff_ffff_ffff_f000
`define SFP_FLOW_CAP_BIT 6
`define SFP_IDX_W 32
`define SFP_PG_CNT_W 8
`endif

/* File: include/sfp_pkg.sv */
// Types for the state-save-area frame pop leaf
package sfp_pkg;
   typedef enum logic [1:0] {
      SFP_FAULT_NONE,
      SFP_FAULT_GP,
      SFP_FAULT_PF
   } sfp_fault_t;
   typedef enum logic [1:0] {
      SFP_REGULAR_PAGE_TYPE,
      SFP_SHADOW_RESTORE_PAGE_TYPE,
      SFP_PT_OTHER
   } sfp_ptype_t;
endpackage : sfp_pkg

/* File: verilog/sfp_page_check.sv */
// Page-cache map entry check for one save page
`timescale 1ns/1ps
module sfp_page_check (
   input wire logic in_cache_in,
   input wire logic valid_in,
   input wire logic blocked_in,
   input wire logic pending_in,
   input wire logic modified_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic addr_match_in,
   input wire logic owner_match_in,
   input wire logic type_match_in,
   output logic ok_out
);
   // All attribute fields sampled together in one cycle, so one check is atomic
   assign ok_out = in_cache_in & valid_in & ~blocked_in & ~pending_in & ~modified_in
      & rd_in & wr_in & addr_match_in & owner_match_in & type_match_in;
endmodule : sfp_page_check

/* File: dv/tb_top.sv */
// Self-checking bench for the save-index decrement leaf
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); end end
module tb_top;
   import sfp_pkg::*;
   typedef struct packed {
      logic en; logic busy; logic cap; logic ss; logic bt; logic m64;
      logic [31:0] idx; logic [2:0] where; logic [7:0] brk; logic [1:0] lsel; sfp_fault_t exp;
   } sfp_tb_row_t;
   localparam logic [63:0] BASE = 64'h0010_0000;
   localparam logic [63:0] OFF = 64'h2000;
   localparam logic [63:0] FOFF = 64'h4_0000;
   localparam logic [63:0] GREG = 64'h100;
   localparam logic [63:0] PHOFF = 64'h1_0000_0000;
   localparam logic [7:0] PGS = 8'h03;
   logic clk_sys_in = 1'b0, rstn_in = 1'b0, op_valid_in = 1'b0;
   logic [7:0] leaf_sel_in = 8'h09;
   logic in_enclave_in, thread_busy_in, mode64_in, flow_cap_in;
   logic shadow_stack_enable_in, branch_tracking_enable_in;
   logic [31:0] current_save_index_in;
   logic [63:0] save_area_offset_in = OFF, flow_save_offset_in = FOFF, enclave_base_in = BASE;
   logic [7:0] save_frame_pages_in = PGS, xsave_pages_in = 8'h01;
   logic [63:0] reg_area_bytes_in = GREG, ds_limit_in;
   logic pg_in_cache_in, pg_valid_in, pg_blocked_in, pg_pending_in, pg_modified_in;
   logic pg_rd_in, pg_wr_in, pg_owner_match_in, hit;
   logic [63:0] pg_enclave_addr_in, pg_phys_in, probe_addr_out, fault_addr_out, reg_area_pa_out;
   sfp_ptype_t pg_type_in;
   logic thread_lock_out, done_out, index_wr_out, wr_seen, done_seen;
   sfp_fault_t fault_out;
   logic [31:0] index_wdata_out, wr_val;
   logic [16*64-1:0] xsave_pa_out;
   sfp_tb_row_t cur, rows[19];
   int errors = 0, checked = 0;
   logic [63:0] pa_exp = 64'h0;
   sfp_frame_pop dut (.clk_sys_in, .rstn_in, .op_valid_in, .leaf_sel_in, .in_enclave_in,
      .thread_busy_in, .mode64_in, .flow_cap_in, .shadow_stack_enable_in,
      .branch_tracking_enable_in, .current_save_index_in, .save_area_offset_in,
      .flow_save_offset_in, .enclave_base_in, .save_frame_pages_in, .xsave_pages_in,
      .reg_area_bytes_in, .ds_limit_in, .pg_in_cache_in, .pg_valid_in, .pg_blocked_in,
      .pg_pending_in, .pg_modified_in, .pg_rd_in, .pg_wr_in, .pg_enclave_addr_in,
      .pg_owner_match_in, .pg_type_in, .pg_phys_in, .probe_addr_out, .thread_lock_out,
      .done_out, .fault_out, .fault_addr_out, .index_wr_out, .index_wdata_out,
      .reg_area_pa_out, .xsave_pa_out);
   always #10 clk_sys_in = ~clk_sys_in;
   function automatic logic [63:0] frame(input logic [31:0] i);
      return OFF + BASE + 64'h1000 * {56'h0, PGS} * ({32'h0, i} - 64'h1);
   endfunction : frame
   function automatic logic [63:0] gpr(input logic [31:0] i);
      return frame(i) + 64'h1000 * {56'h0, PGS} - GREG;
   endfunction : gpr
   function automatic logic [63:0] flow(input logic [31:0] i);
      return (FOFF + BASE + ({32'h0, i} - 64'h1) * 64'h10) & 64'hffff_ffff_ffff_f000;
   endfunction : flow
   function automatic logic [63:0] bad_at(input sfp_tb_row_t r);
      case (r.where)
         3'h1: return frame(r.idx);
         3'h2: return frame(r.idx) + 64'h1000;
         3'h3: return gpr(r.idx);
         3'h4: return flow(r.idx);
         default: return 64'hffff_ffff_ffff_f000;
      endcase
   endfunction : bad_at
   // Map entry answers the probe in the same cycle; one flag broken on the chosen page
   always_comb begin
      hit = probe_addr_out[63:12] == bad_at(cur) >> 12;
      // Map entry holds the page address, not the probed byte
      pg_enclave_addr_in = probe_addr_out & 64'hffff_ffff_ffff_f000;
      pg_phys_in = probe_addr_out + PHOFF;
      pg_type_in = (probe_addr_out[63:12] == flow(cur.idx) >> 12) ? SFP_SHADOW_RESTORE_PAGE_TYPE : SFP_REGULAR_PAGE_TYPE;
      pg_in_cache_in = !(hit && cur.brk[0]);
      pg_valid_in = !(hit && cur.brk[1]);
      pg_blocked_in = hit && cur.brk[2];
      pg_pending_in = hit && cur.brk[3];
      pg_modified_in = hit && cur.brk[4];
      pg_rd_in = !(hit && cur.brk[5]);
      pg_wr_in = !(hit && cur.brk[6]);
      pg_owner_match_in = !(hit && cur.brk[7]);
   end
   // Sampled mid-cycle, away from the edge that launches the pulses
   always @(negedge clk_sys_in) begin
      if (index_wr_out === 1'b1) begin
         wr_seen <= 1'b1;
         wr_val <= index_wdata_out;
      end
      if (done_out === 1'b1) begin
         done_seen <= 1'b1;
      end
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic start(input sfp_tb_row_t r, input logic [7:0] sel);
      cur = r;
      {in_enclave_in, thread_busy_in, flow_cap_in} = {r.en, r.busy, r.cap};
      {shadow_stack_enable_in, branch_tracking_enable_in, mode64_in} = {r.ss, r.bt, r.m64};
      current_save_index_in = r.idx;
      ds_limit_in = (r.lsel == 2'h0) ? 64'hffff_ffff_ffff_ffff
         : gpr(r.idx) + GREG - {62'h0, r.lsel};
      leaf_sel_in = sel;
      wr_seen = 1'b0;
      done_seen = 1'b0;
      op_valid_in = 1'b1;
      @(posedge clk_sys_in);
      #1 op_valid_in = 1'b0;
   endtask : start
   task automatic run(input sfp_tb_row_t r, input int n);
      int k;
      start(r, 8'h09);
      for (k = 0; k < 200 && done_out !== 1'b1; k++) begin
         @(posedge clk_sys_in);
         #1;
      end
      if (k == 200) begin
         errors++;
         $display("MISMATCH done expected within 200 cycles");
         finish_test();
      end
      `CHK("fault", r.exp, fault_out)
      if (r.exp == SFP_FAULT_PF) `CHK("fault_addr", bad_at(r), fault_addr_out)
      `CHK("index_wr", r.exp == SFP_FAULT_NONE, wr_seen)
      `CHK("lock", 1'b0, thread_lock_out)
      // A failed leaf must leave the previous cached address in place
      if (r.exp == SFP_FAULT_NONE) pa_exp = gpr(r.idx) + PHOFF;
      `CHK("reg_pa", pa_exp, reg_area_pa_out)
      if (r.exp == SFP_FAULT_NONE) begin
         `CHK("index", r.idx - 32'h1, wr_val)
         `CHK("xs_pa0", frame(r.idx) + PHOFF, xsave_pa_out[63:0])
         `CHK("xs_pa1", frame(r.idx) + 64'h1000 + PHOFF, xsave_pa_out[127:64])
      end
      $display("test %0d finished", n);
   endtask : run
   initial begin
      cur = '0;
      start(cur, 8'h00);
      rows = '{'{0,0,1,1,0,1,3,0,0,0,SFP_FAULT_GP}, '{1,1,1,1,0,1,3,0,0,0,SFP_FAULT_GP},
         '{1,0,1,1,0,1,0,0,0,0,SFP_FAULT_GP}, '{0,0,1,1,0,1,0,0,0,0,SFP_FAULT_GP},
         '{1,0,1,1,0,1,3,0,0,0,SFP_FAULT_NONE}, '{1,0,1,1,0,1,3,1,1,0,SFP_FAULT_PF},
         '{1,0,1,1,0,1,2,2,2,0,SFP_FAULT_PF}, '{1,0,1,1,0,1,3,1,4,0,SFP_FAULT_PF},
         '{1,0,1,1,0,1,3,2,8,0,SFP_FAULT_PF}, '{1,0,1,1,0,1,3,1,16,0,SFP_FAULT_PF},
         '{1,0,1,1,0,1,3,2,32,0,SFP_FAULT_PF}, '{1,0,1,1,0,1,3,3,64,0,SFP_FAULT_PF},
         '{1,0,1,1,0,1,3,4,128,0,SFP_FAULT_PF}, '{1,0,0,1,0,1,3,4,2,0,SFP_FAULT_NONE},
         '{1,0,1,0,1,1,2,4,2,0,SFP_FAULT_PF}, '{1,0,1,1,0,0,3,0,0,2,SFP_FAULT_GP},
         '{1,0,1,1,0,0,3,0,0,1,SFP_FAULT_NONE}, '{1,0,1,1,0,1,1,0,0,0,SFP_FAULT_NONE},
         '{1,0,1,0,0,1,2,4,2,0,SFP_FAULT_NONE}};
      repeat (8) @(posedge clk_sys_in);
      #1 rstn_in = 1'b1;
      `CHK("rst_fault", SFP_FAULT_NONE, fault_out)
      `CHK("rst_done", 1'b0, done_out)
      foreach (rows[i]) run(rows[i], i);
      // Any other selector must leave the block idle; let the last done pulse pass
      repeat (2) @(posedge clk_sys_in);
      #1 start(rows[4], 8'h02);
      repeat (20) @(posedge clk_sys_in);
      #1 `CHK("other_leaf", 1'b0, done_seen | wr_seen)
      $display("test other_leaf finished");
      // Reset in mid-walk: nothing may commit
      start(rows[4], 8'h09);
      @(posedge clk_sys_in);
      #1 rstn_in = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 rstn_in = 1'b1;
      repeat (20) @(posedge clk_sys_in);
      #1 `CHK("abort_wr", 1'b0, wr_seen)
      `CHK("abort_lock", 1'b0, thread_lock_out)
      `CHK("abort_pa", 64'h0, reg_area_pa_out)
      $display("test reset_abort finished");
      run(rows[4], 99);
      finish_test();
   end
endmodule : tb_top
